// [wrc_pkg.sv]
// Constants, types and register map of the watchdog and reset control block.
// Assumes one 40 MHz clock and a synchronous active-low reset.
package wrc_pkg;
    // ==========================================
    // Register offsets and field layout
    localparam logic [7:0] OFF_WDOG_CTRL = 8'h00;
    localparam logic [7:0] OFF_RST_FLAGS = 8'h01;
    localparam logic [7:0] OFF_LV_CTRL = 8'h02;
    localparam logic [7:0] OFF_STATUS = 8'h03;
    localparam int KEY_LSB = 3;
    localparam int FLG_WDOG_KEY = 0;
    localparam int FLG_LV_KEY = 1;
    localparam int FLG_LV_RST = 2;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_POWERDOWN = 1;
    // ==========================================
    // Reset values and key codes
    localparam logic [7:0] WDOG_CTRL_POR = 8'h53;
    localparam logic [7:0] LV_CTRL_POR = 8'h5a;
    localparam logic [4:0] WDOG_KEY_EN = 5'h0a;
    localparam logic [4:0] WDOG_KEY_DIS = 5'h15;
    localparam logic [7:0] LV_KEY_EN = 8'h5a;
    localparam logic [7:0] LV_KEY_DIS = 8'ha5;
    localparam logic [2:0] FLAGS_POR = 3'h0;
    // ==========================================
    // Timing
    localparam int CLK_FREQ_HZ = 40000000;
    localparam int SLOW_RC_HZ = 32000;
    localparam logic [3:0] PERIOD_BASE_EXP = 4'h8;
    localparam int SOFT_RESET_DELAY_TICKS = 4;
    localparam int LV_FILTER_NS_DEF = 100000;
    // ==========================================
    // Carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wrc_bus_s;
    typedef struct packed {
        logic halt;
        logic clear_watchdog_instr;
        logic sleep;
    } wrc_core_s;
    typedef struct packed {
        logic full;
        logic pc_sp;
    } wrc_rst_s;
    typedef enum logic [1:0] {
        SR_IDLE = 2'b00,
        SR_WAIT = 2'b01,
        SR_FIRE = 2'b11
    } wrc_sr_e;
endpackage

// [wrc_sync_edge.sv]
// Two-flop synchroniser with a rising-edge pulse on the clean side.
// Assumes the input is asynchronous to i_clk and slower than it.
`timescale 1ns/10ps
`default_nettype none
module wrc_sync_edge (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_level,
    output logic o_rise
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // ==========================================
    // Only sync_r reads meta_r; the edge compare looks at later stages
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_rise = sync_r & ~last_r;
endmodule
`default_nettype wire

// [wrc_top.sv]
// Watchdog timer with key-protected control and the supervisory reset logic.
// Assumes the core gives one-cycle halt and clear pulses and a sleep level.
// How it works
// [R1] Watchdog counts ticks of the slow RC clock, dividing by 2^8 to 2^15.
// [R2] Period select n gives a time-out of 2^(8+n) slow ticks.
// [R3] Enable key 10101B disables the watchdog, 01010B enables it.
// [R4] Any other enable key gives full reset after soft delay, sets key flag.
// [R5] Watchdog key flag is set by hardware only, cleared by writing zero.
// [R6] Power-on loads enable key 01010B so the watchdog runs.
// [R7] Overflow in normal run gives full reset and sets time-out flag.
// [R8] Overflow in sleep sets time-out flag and resets only PC and SP.
// [R9] Counter cleared by bad key, clear instruction, halt, overflow or low-voltage reset.
// [R10] Software must clear the watchdog before its time-out expires.
// [R11] Power-on reset holds full reset: PC zero, port registers high.
// [R12] Low supply gives reset only if it lasts beyond the filter time.
// [R13] A valid low-voltage reset sets the low-voltage reset flag.
// [R14] Select key 01011010B enables low-voltage reset, 10100101B disables it.
// [R15] Other select key gives reset after soft delay, sets its key flag.
// [R16] Power-on loads select key 01011010B.
// [R17] Low-voltage detection is off in sleep or idle.
// [R18] Upper five bits of the flag register read zero.
// [R19] Halt sets power-down, clears time-out flag and watchdog counter.
// [R20] Power-down flag cleared at power-up and by the clear instruction.
// [R21] Low-voltage flags cleared only by software writing zero.
// [R22] Soft reset delay is a parameter counted in slow ticks.
// [R23] Stored keys compared to both valid codes every cycle.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module wrc_top #(
    parameter int LV_FILTER_NS = wrc_pkg::LV_FILTER_NS_DEF,
    parameter int SOFT_DELAY_TICKS = wrc_pkg::SOFT_RESET_DELAY_TICKS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_slow_rc_clk,
    input wire logic i_low_supply,
    input wire wrc_pkg::wrc_core_s i_core,
    input wire wrc_pkg::wrc_bus_s i_bus,
    output logic [7:0] o_rd_data,
    output wrc_pkg::wrc_rst_s o_rst,
    output logic o_timeout_flag,
    output logic o_powerdown_flag
);
    // ==========================================
    // Derived counts
    localparam int LV_FILTER_CYC = (LV_FILTER_NS * (wrc_pkg::CLK_FREQ_HZ / 1000000) + 999) / 1000;
    localparam logic [19:0] LV_SAT = 20'(LV_FILTER_CYC + 1);
    localparam logic [7:0] SR_LAST = 8'(SOFT_DELAY_TICKS - 1);

    logic [7:0] wd_ctrl_r;
    logic [7:0] lv_ctrl_r;
    logic [2:0] flags_r;
    logic [14:0] wd_cnt_r;
    logic [19:0] lv_cnt_r;
    logic [7:0] sr_cnt_r;
    logic sr_wd_r;
    logic sr_lv_r;
    wrc_pkg::wrc_sr_e sr_state_r;
    wrc_pkg::wrc_sr_e sr_state_nxt;
    logic slow_tick;
    logic low_lvl;
    logic [4:0] wd_key;
    logic [2:0] wd_sel;
    logic wd_en;
    logic wd_bad;
    logic lv_bad;
    logic wd_clr;
    logic wd_ovf;
    logic lv_active;
    logic lv_fire;
    logic sr_fire;
    logic full_req;
    logic pcsp_req;
    logic [14:0] limit_m1;
    logic wr_flags;

    // ==========================================
    // Pin synchronisers: slow RC clock edge and low-supply level
    wrc_sync_edge u_slow_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_slow_rc_clk),
        .o_level(),
        .o_rise(slow_tick)
    );

    wrc_sync_edge u_low_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_low_supply),
        .o_level(low_lvl),
        .o_rise()
    );

    // ==========================================
    // Key decode, checked every cycle so a flipped bit is caught at once
    assign wd_key = wd_ctrl_r[7:wrc_pkg::KEY_LSB];
    assign wd_sel = wd_ctrl_r[wrc_pkg::KEY_LSB-1:0];
    assign wd_en = (wd_key == wrc_pkg::WDOG_KEY_EN); // R3
    assign wd_bad = !wd_en && (wd_key != wrc_pkg::WDOG_KEY_DIS); // R23
    assign lv_bad = (lv_ctrl_r != wrc_pkg::LV_KEY_EN) && (lv_ctrl_r != wrc_pkg::LV_KEY_DIS); // R23
    assign sr_fire = (sr_state_r == wrc_pkg::SR_FIRE);
    assign wr_flags = i_bus.wr && (i_bus.addr == wrc_pkg::OFF_RST_FLAGS);

    // Terminal count for the selected period, 2^(8+n) ticks
    assign limit_m1 = 15'((16'h0001 << (wrc_pkg::PERIOD_BASE_EXP + {1'b0, wd_sel})) - 16'h0001); // R2

    // ==========================================
    // Reset requests; a sleeping overflow only restarts PC and SP
    assign wd_ovf = wd_en && slow_tick && (wd_cnt_r == limit_m1) && !wd_clr; // R1
    assign lv_active = (lv_ctrl_r == wrc_pkg::LV_KEY_EN) && !i_core.sleep && low_lvl; // R14 R17
    assign lv_fire = lv_active && (lv_cnt_r == 20'(LV_FILTER_CYC)); // R12
    assign full_req = sr_fire || lv_fire || (wd_ovf && !i_core.sleep); // R7
    assign pcsp_req = wd_ovf && i_core.sleep; // R8
    assign wd_clr = wd_bad || i_core.clear_watchdog_instr || i_core.halt || sr_fire || lv_fire; // R9

    // ==========================================
    // Watchdog counter; a disabled watchdog holds its value unless cleared
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            wd_cnt_r <= '0;
        else if (wd_clr || wd_ovf)
            wd_cnt_r <= '0; // R9 R19
        else if (wd_en && slow_tick)
            wd_cnt_r <= wd_cnt_r + 15'h0001; // R1
    end

    // ==========================================
    // Low-supply filter; saturates so one dip gives one reset
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            lv_cnt_r <= '0;
        else if (!lv_active)
            lv_cnt_r <= '0; // R12
        else if (lv_cnt_r != LV_SAT)
            lv_cnt_r <= lv_cnt_r + 20'h00001;
    end

    // ==========================================
    // Soft reset sequencer after a corrupted key
    always_comb
    begin
        sr_state_nxt = sr_state_r;
        unique case (sr_state_r)
            wrc_pkg::SR_IDLE:
                if (wd_bad || lv_bad)
                    sr_state_nxt = wrc_pkg::SR_WAIT; // R4 R15
            wrc_pkg::SR_WAIT:
                if (slow_tick && (sr_cnt_r == SR_LAST))
                    sr_state_nxt = wrc_pkg::SR_FIRE; // R22
            wrc_pkg::SR_FIRE:
                sr_state_nxt = wrc_pkg::SR_IDLE;
            default:
                sr_state_nxt = wrc_pkg::SR_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            sr_state_r <= wrc_pkg::SR_IDLE;
        else
            sr_state_r <= sr_state_nxt;
    end

    // Delay counter and the source of the pending soft reset
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            sr_cnt_r <= '0;
            sr_wd_r <= 1'b0;
            sr_lv_r <= 1'b0;
        end
        else if (sr_state_r == wrc_pkg::SR_IDLE)
        begin
            sr_cnt_r <= '0;
            sr_wd_r <= wd_bad;
            sr_lv_r <= lv_bad;
        end
        else if (sr_state_r == wrc_pkg::SR_WAIT)
        begin
            sr_wd_r <= sr_wd_r | wd_bad;
            sr_lv_r <= sr_lv_r | lv_bad;
            if (slow_tick)
                sr_cnt_r <= sr_cnt_r + 8'h01; // R22
        end
    end

    // ==========================================
    // Control registers; a hardware restore beats a same-cycle write
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            wd_ctrl_r <= wrc_pkg::WDOG_CTRL_POR; // R6
        else if (full_req)
            wd_ctrl_r <= wrc_pkg::WDOG_CTRL_POR;
        else if (i_bus.wr && (i_bus.addr == wrc_pkg::OFF_WDOG_CTRL))
            wd_ctrl_r <= i_bus.wdata;
    end

    // Low-voltage key survives its own reset, not a key or run-mode watchdog reset
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            lv_ctrl_r <= wrc_pkg::LV_CTRL_POR; // R16
        else if (sr_fire || (wd_ovf && !i_core.sleep))
            lv_ctrl_r <= wrc_pkg::LV_CTRL_POR; // R15
        else if (i_bus.wr && (i_bus.addr == wrc_pkg::OFF_LV_CTRL))
            lv_ctrl_r <= i_bus.wdata;
    end

    // ==========================================
    // Reset source flags; set wins over a clearing write
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            flags_r <= wrc_pkg::FLAGS_POR;
        else
        begin
            if (sr_fire && sr_wd_r)
                flags_r[wrc_pkg::FLG_WDOG_KEY] <= 1'b1; // R4 R5
            else if (wr_flags && !i_bus.wdata[wrc_pkg::FLG_WDOG_KEY])
                flags_r[wrc_pkg::FLG_WDOG_KEY] <= 1'b0; // R5
            if (sr_fire && sr_lv_r)
                flags_r[wrc_pkg::FLG_LV_KEY] <= 1'b1; // R15
            else if (wr_flags && !i_bus.wdata[wrc_pkg::FLG_LV_KEY])
                flags_r[wrc_pkg::FLG_LV_KEY] <= 1'b0; // R21
            if (lv_fire)
                flags_r[wrc_pkg::FLG_LV_RST] <= 1'b1; // R13
            else if (wr_flags && !i_bus.wdata[wrc_pkg::FLG_LV_RST])
                flags_r[wrc_pkg::FLG_LV_RST] <= 1'b0; // R21
        end
    end

    // ==========================================
    // Status flags: time-out and power-down
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_timeout_flag <= 1'b0;
            o_powerdown_flag <= 1'b0; // R20
        end
        else
        begin
            if (wd_ovf)
                o_timeout_flag <= 1'b1; // R7 R8
            else if (i_core.halt)
                o_timeout_flag <= 1'b0; // R19
            if (i_core.halt)
                o_powerdown_flag <= 1'b1; // R19
            else if (i_core.clear_watchdog_instr)
                o_powerdown_flag <= 1'b0; // R20
        end
    end

    // ==========================================
    // Reset outputs; full reset is held through power-on reset so the core
    // zeroes its PC and drives all port data and direction bits high
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_rst.full <= 1'b1; // R11
            o_rst.pc_sp <= 1'b1;
        end
        else
        begin
            o_rst.full <= full_req; // R4 R7
            o_rst.pc_sp <= pcsp_req || full_req; // R8
        end
    end

    // ==========================================
    // Read port: data stands only in the cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || !i_bus.rd)
            o_rd_data <= 8'h00;
        else
        begin
            unique case (i_bus.addr)
                wrc_pkg::OFF_WDOG_CTRL: o_rd_data <= wd_ctrl_r;
                wrc_pkg::OFF_RST_FLAGS: o_rd_data <= {5'h00, flags_r}; // R18
                wrc_pkg::OFF_LV_CTRL: o_rd_data <= lv_ctrl_r;
                wrc_pkg::OFF_STATUS: o_rd_data <= {6'h00, o_powerdown_flag, o_timeout_flag};
                default: o_rd_data <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // Checks
    wd_run_rst_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
        wd_ovf && !i_core.sleep |=> o_rst.full && o_timeout_flag)
        else $error("watchdog overflow in run gave no full reset");

    wd_sleep_rst_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
        wd_ovf && i_core.sleep |=> o_rst.pc_sp && !o_rst.full && o_timeout_flag)
        else $error("sleeping overflow reset wrong");

    wd_dis_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
        (wd_key == wrc_pkg::WDOG_KEY_DIS) && !wd_clr |=> $stable(wd_cnt_r))
        else $error("disabled watchdog counted");

    wd_clr_cnt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
        i_core.clear_watchdog_instr || i_core.halt |=> wd_cnt_r == 15'h0000)
        else $error("counter not cleared");

    key_fire_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
        sr_fire && sr_wd_r |=> o_rst.full && flags_r[wrc_pkg::FLG_WDOG_KEY]
            && (wd_ctrl_r == wrc_pkg::WDOG_CTRL_POR))
        else $error("bad key reset missing");

    key_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R23
        (sr_state_r == wrc_pkg::SR_IDLE) && lv_bad |=> sr_state_r == wrc_pkg::SR_WAIT)
        else $error("bad select key not caught");

    lv_filter_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
        lv_fire |-> $past(lv_active) && $past(lv_active, 2))
        else $error("low supply reset without persistence");

    lv_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
        lv_fire |=> o_rst.full && flags_r[wrc_pkg::FLG_LV_RST])
        else $error("low voltage reset flag not set");

    lv_sleep_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
        i_core.sleep |-> !lv_fire ##1 (!lv_fire)[*2])
        else $error("low voltage reset in sleep");

    halt_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R19
        i_core.halt && !wd_ovf |=> o_powerdown_flag && !o_timeout_flag)
        else $error("halt flags wrong");

    clr_pdf_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
        i_core.clear_watchdog_instr && !i_core.halt |=> !o_powerdown_flag)
        else $error("power-down flag not cleared");

    flag_upper_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
        i_bus.rd && (i_bus.addr == wrc_pkg::OFF_RST_FLAGS) |=> o_rd_data[7:3] == 5'h00)
        else $error("flag register upper bits not zero");

    por_keys_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
        $rose(i_rst_n) |-> wd_en && (lv_ctrl_r == wrc_pkg::LV_KEY_EN) && o_rst.full)
        else $error("power-on keys wrong");

    flag_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R21
        flags_r[wrc_pkg::FLG_LV_RST] && !wr_flags |=> flags_r[wrc_pkg::FLG_LV_RST])
        else $error("low voltage flag cleared by hardware");
endmodule
`default_nettype wire

// [wrc_core_model.sv]
// Behavioural processor core: clear and halt pulses plus the sleep level.
// Assumes the testbench calls its tasks from one process, after reset.
`timescale 1ns/10ps
`default_nettype none
module wrc_core_model (
    input wire logic i_clk,
    output var wrc_pkg::wrc_core_s o_core
);
    // ==========================================
    // Instruction pulses
    initial o_core = '0;
    // One-cycle pulse; halt and clear never share a cycle, as in a real core
    task automatic issue(input logic is_halt);
        @(posedge i_clk);
        o_core.halt <= is_halt;
        o_core.clear_watchdog_instr <= !is_halt;
        @(posedge i_clk);
        o_core.halt <= 1'b0;
        o_core.clear_watchdog_instr <= 1'b0;
    endtask
    // Sleep or idle level, changed right after an edge
    task automatic set_sleep(input logic lvl);
        @(posedge i_clk);
        o_core.sleep <= lvl;
    endtask
    // Healthy software: clears every gap+2 cycles, gap below the time-out
    task automatic service(input int rounds, input int gap);
        repeat (rounds)
        begin
            repeat (gap) @(posedge i_clk);
            issue(1'b0);
        end
    endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench of the watchdog and reset control block.
// Assumes the slow clock may run far faster than in silicon.
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int SOFT_TICKS = 2;
    localparam int LV_NS = 1000;
    localparam int LV_CYC = (LV_NS * 40 + 999) / 1000;
    logic i_clk;
    logic i_rst_n;
    logic slow_clk;
    logic low_supply;
    wrc_pkg::wrc_core_s core_sig;
    wrc_pkg::wrc_bus_s bus;
    logic [7:0] rd_data;
    wrc_pkg::wrc_rst_s rst_req;
    logic to_flag;
    logic pd_flag;
    logic last_full = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;
    int ticks = 0;
    int n_rst = 0;
    int mdl[8];

    // ==========================================
    // Clocks and instances
    // Slow clock phase is unrelated to the system clock on purpose
    always #12.5 i_clk = ~i_clk;
    always #130 slow_clk = ~slow_clk;
    wrc_core_model core (.i_clk(i_clk), .o_core(core_sig));
    wrc_top #(.LV_FILTER_NS(LV_NS), .SOFT_DELAY_TICKS(SOFT_TICKS)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow_rc_clk(slow_clk),
        .i_low_supply(low_supply), .i_core(core_sig), .i_bus(bus),
        .o_rd_data(rd_data), .o_rst(rst_req), .o_timeout_flag(to_flag),
        .o_powerdown_flag(pd_flag));

    // Count slow ticks and reset pulses seen after power-on
    always @(posedge slow_clk) ticks++;
    always @(posedge i_clk)
        if (i_rst_n && (rst_req.full || rst_req.pc_sp))
        begin
            last_full = rst_req.full;
            n_rst++;
        end

    // ==========================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Power-on, run-overflow and key resets restore both control registers in the model
    task automatic por_model();
        mdl[0] = 8'h53;
        mdl[2] = 8'h5a;
    endtask
    // Flag register: a one written leaves the flag, a zero clears it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        bus <= '0;
        if (a == 8'h01)
            mdl[1] = mdl[1] & d & 7;
        else if (a == 8'h00 || a == 8'h02)
            mdl[a[1:0]] = d;
    endtask
    task automatic rchk(input logic [7:0] a);
        logic [7:0] q;
        @(posedge i_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        bus <= '0;
        #1 q = rd_data;
        chk($sformatf("reg %0h", a), {24'h0, q}, mdl[a[2:0]]);
    endtask
    // Bounded wait for a reset pulse; dt is slow ticks since t0, -1 if none
    task automatic wait_rst(input int t0, input int lim, output int dt);
        int base;
        base = n_rst;
        dt = -1;
        for (int i = 0; i < lim && dt < 0; i++)
        begin
            @(posedge i_clk);
            #1;
            if (n_rst != base) dt = ticks - t0;
        end
    endtask
    task automatic dip(input int cyc);
        @(posedge i_clk);
        low_supply <= 1'b1;
        repeat (cyc) @(posedge i_clk);
        low_supply <= 1'b0;
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        int dt;
        int e;
        logic [4:0] bad;
        logic [7:0] lvbad;
        // Idle levels at time zero, before the first edge of either clock
        i_clk = 1'b0;
        slow_clk = 1'b0;
        i_rst_n = 1'b0;
        low_supply = 1'b0;
        bus = '0;
        void'($urandom(32'h64d3));
        por_model();
        repeat (2) @(posedge i_clk);
        #1 chk("full in reset", rst_req.full, 1);
        chk("pc_sp in reset", rst_req.pc_sp, 1);
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int a = 0; a < 8; a++)
            rchk(8'(a));
        // Run-mode overflow for the two shortest periods
        for (int s = 0; s < 2; s++)
        begin
            e = 1 << (8 + s);
            wr(8'h00, {wrc_pkg::WDOG_KEY_EN, 3'(s)});
            core.issue(1'b0);
            wait_rst(ticks, 12000, dt);
            chk("run period", dt inside {[e - 1:e + 1]} ? e : dt, e);
            chk("run full", last_full, 1);
            chk("timeout flag", to_flag, 1);
            por_model();
            mdl[3] = 1;
            rchk(8'h00);
            rchk(8'h03);
        end
        // Regular clears hold off the time-out; halt then sleep overflow
        wr(8'h00, {wrc_pkg::WDOG_KEY_EN, 3'h0});
        dt = n_rst;
        core.service(4, 2000);
        chk("serviced", n_rst, dt);
        // Let the count build up so only the halt's own clear gives the full period
        repeat (1000) @(posedge i_clk);
        core.set_sleep(1'b1);
        core.issue(1'b1);
        #1 chk("halt pdf", pd_flag, 1);
        chk("halt to", to_flag, 0);
        wait_rst(ticks, 4000, dt);
        chk("sleep period", dt inside {[255:257]} ? 256 : dt, 256);
        chk("sleep pc_sp only", last_full, 0);
        chk("sleep to", to_flag, 1);
        mdl[3] = 3;
        rchk(8'h00);
        rchk(8'h03);
        core.set_sleep(1'b0);
        core.issue(1'b0);
        #1 chk("clear pdf", pd_flag, 0);
        // Disabled watchdog never fires
        wr(8'h00, {wrc_pkg::WDOG_KEY_DIS, 3'h0});
        wait_rst(ticks, 3500, dt);
        chk("disabled", dt, -1);
        // Corrupted enable key
        bad = 5'($urandom_range(31));
        while (bad == wrc_pkg::WDOG_KEY_EN || bad == wrc_pkg::WDOG_KEY_DIS)
            bad = 5'($urandom_range(31));
        wr(8'h00, {bad, 3'h5});
        wait_rst(ticks, 300, dt);
        chk("soft delay", dt inside {[1:3]} ? SOFT_TICKS : dt, SOFT_TICKS);
        por_model();
        mdl[1] = 1;
        rchk(8'h01);
        rchk(8'h00);
        wr(8'h01, 8'hff);
        rchk(8'h01);
        wr(8'h01, 8'h00);
        rchk(8'h01);
        // Corrupted low-voltage key
        lvbad = 8'($urandom_range(255));
        while (lvbad == wrc_pkg::LV_KEY_EN || lvbad == wrc_pkg::LV_KEY_DIS)
            lvbad = 8'($urandom_range(255));
        wr(8'h02, lvbad);
        wait_rst(ticks, 300, dt);
        chk("lv key soft delay", dt inside {[1:3]} ? SOFT_TICKS : dt, SOFT_TICKS);
        por_model();
        mdl[1] = 2;
        rchk(8'h02);
        rchk(8'h01);
        wr(8'h01, 8'h00);
        rchk(8'h01);
        // Low supply: short dip ignored, long dip resets, sleep and key mask it
        wr(8'h00, 8'ha8);
        fork
            dip(LV_CYC - 10);
            wait_rst(ticks, 200, dt);
        join
        chk("short dip", dt, -1);
        fork
            dip(LV_CYC + 20);
            wait_rst(ticks, 200, dt);
        join
        chk("long dip", dt >= 0, 1);
        mdl[1] = 4;
        mdl[0] = 8'h53;
        rchk(8'h01);
        rchk(8'h02);
        rchk(8'h00);
        core.set_sleep(1'b1);
        fork
            dip(LV_CYC + 20);
            wait_rst(ticks, 200, dt);
        join
        chk("sleep dip", dt, -1);
        core.set_sleep(1'b0);
        wr(8'h02, wrc_pkg::LV_KEY_DIS);
        fork
            dip(LV_CYC + 20);
            wait_rst(ticks, 200, dt);
        join
        chk("disabled dip", dt, -1);
        results();
    end

    // Hang guard, about two and a half times the expected run
    initial
    begin
        #1500000;
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
